// File: core/dtl_pkg.sv
// Purpose: shared constants and types for the discrete timer logic unit
// Assumes: one clock, one execution tick enable
// Notes: times are unsigned tick counts
package dtl_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int DTL_NUM_IN = 4;
    localparam int DTL_TW = 16;
    localparam int DTL_CW = 16;

    // ----------------------------------------
    // inversion_select bit positions
    // ----------------------------------------
    localparam int DTL_INV_IN0_POS = 0;
    localparam int DTL_INV_RST_POS = 4;
    localparam int DTL_INV_OUT_POS = 5;
    localparam int DTL_INV_PRE_POS = 6;
    localparam int DTL_INV_W = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [DTL_TW-1:0] DTL_TIME_RST = 16'h0000;
    localparam logic [DTL_CW-1:0] DTL_CNT_RST = 16'h0000;

    // ----------------------------------------
    // enumerations
    // ----------------------------------------
    typedef enum logic [3:0] {
        DTL_CMB_OR = 4'h0,
        DTL_CMB_TWO_OR_MORE = 4'h1,
        DTL_CMB_THREE_OR_MORE = 4'h2,
        DTL_CMB_AND = 4'h3,
        DTL_CMB_EXACT_ONE = 4'h4,
        DTL_CMB_EXACT_TWO = 4'h5,
        DTL_CMB_EXACT_THREE = 4'h6,
        DTL_CMB_EVEN = 4'h7,
        DTL_CMB_ODD = 4'h8
    } dtl_comb_t;

    typedef enum logic [3:0] {
        DTL_TMR_MEASURE = 4'h0,
        DTL_TMR_ACCUMULATE = 4'h1,
        DTL_TMR_COMPARE = 4'h2,
        DTL_TMR_DELAY = 4'h3,
        DTL_TMR_EXTEND = 4'h4,
        DTL_TMR_DEBOUNCE = 4'h5,
        DTL_TMR_PULSE = 4'h6,
        DTL_TMR_RETRIGGER = 4'h7
    } dtl_timer_t;

    typedef enum logic [1:0] {
        DTL_ST_IDLE = 2'b00,
        DTL_ST_RUN = 2'b01,
        DTL_ST_DONE = 2'b11
    } dtl_state_t;

    typedef enum logic {
        DTL_QOPT_CLEAR = 1'b0,
        DTL_QOPT_LAST = 1'b1
    } dtl_qopt_t;
endpackage : dtl_pkg

// File: core/dtl_combiner.sv
// Purpose: reduce up to four discrete inputs to one combined input
// Assumes: inputs already synchronised and inverted
// Notes: pure combinational reduction
`timescale 1ns/1ps
module dtl_combiner
    import dtl_pkg::*;
(
    input wire logic [DTL_NUM_IN-1:0] in_val,
    input wire logic [DTL_NUM_IN-1:0] in_use,
    input wire dtl_pkg::dtl_comb_t input_combine_select,
    output logic combined
);
    // ----------------------------------------
    // voting
    // ----------------------------------------
    logic [2:0] ntrue;
    logic [2:0] nuse;

    // count true and participating inputs
    always_comb begin
        ntrue = 3'h0;
        nuse = 3'h0;
        for (int i = 0; i < DTL_NUM_IN; i++) begin
            ntrue = ntrue + {2'h0, in_val[i] & in_use[i]};
            nuse = nuse + {2'h0, in_use[i]};
        end
    end

    // apply the selected combination
    always_comb begin
        unique case (input_combine_select)
            DTL_CMB_OR: combined = (ntrue >= 3'h1);
            DTL_CMB_TWO_OR_MORE: combined = (ntrue >= 3'h2);
            DTL_CMB_THREE_OR_MORE: combined = (ntrue >= 3'h3);
            DTL_CMB_AND: combined = (nuse != 3'h0) && (ntrue == nuse);
            DTL_CMB_EXACT_ONE: combined = (ntrue == 3'h1);
            DTL_CMB_EXACT_TWO: combined = (ntrue == 3'h2);
            DTL_CMB_EXACT_THREE: combined = (ntrue == 3'h3);
            DTL_CMB_EVEN: combined = ~ntrue[0];
            DTL_CMB_ODD: combined = ntrue[0];
            default: combined = 1'b0;
        endcase
    end
endmodule : dtl_combiner

// File: core/dtl_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: asynchronous inputs
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module dtl_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;

    // two stage capture
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= '0;
            q <= '0;
        end else begin
            s1_ff <= d;
            q <= s1_ff;
        end
    end
endmodule : dtl_sync

// File: core/dtl_timer_logic_unit.sv
// Purpose: timer and logic unit, combine inputs then time the result
// Assumes: exec_tick is a one-cycle pulse from a divider on ref_clk
// Notes: discrete pins are synchronised; configuration is quasi-static
`timescale 1ns/1ps

// Contract
// - up to four inputs reduced to one combined input by selector
// - or, two or more, three or more, and combinations
// - exact one, two or three true inputs
// - even and odd parity of true inputs
// - connected undefined input counts as bad status
// - unconnected undefined input is left out
// - timer function selects measure, delay, extend, pulse, debounce
// - setpoint gives interval; running time checked every execution
// - output follows pre-output in automatic mode
// - elapsed time reports time in current timing
// - idle value option governs times while quiescent
// - measure, compare, delay quiescent while input false
// - extend quiescent while input true
// - debounce quiescent after change with timer expired
// - pulses quiescent when input false and timer expired
// - clear option zeroes both times while quiescent
// - last option holds both times while quiescent
// - rising timer reset zeroes elapsed and remaining
// - combined input rising edges counted and reported
// - inputs inverted before use, outputs inverted after
// - measure: pre-output follows input, elapsed true time, remaining zero
// - plain pulse ignores rising edges during pulse
// - retrigger pulse restarts timer on rising edge
// - counter counts rising edges, cleared on reset rising edge
module dtl_timer_logic_unit
    import dtl_pkg::*;
#(
    parameter int TW = DTL_TW,
    parameter int CW = DTL_CW
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic exec_tick,
    input wire logic [dtl_pkg::DTL_NUM_IN-1:0] din,
    input wire logic [dtl_pkg::DTL_NUM_IN-1:0] din_defined,
    input wire logic [dtl_pkg::DTL_NUM_IN-1:0] din_connected,
    input wire logic timer_reset_in,
    input wire dtl_pkg::dtl_comb_t input_combine_select,
    input wire dtl_pkg::dtl_timer_t timer_function_select,
    input wire dtl_pkg::dtl_qopt_t idle_value_option,
    input wire logic [dtl_pkg::DTL_INV_W-1:0] inversion_select,
    input wire logic [TW-1:0] interval_setpoint,
    input wire logic auto_mode,
    input wire logic [dtl_pkg::DTL_NUM_IN-1:0] manual_out,
    output logic combined_input,
    output logic pre_output,
    output logic discrete_output,
    output logic [TW-1:0] elapsed_time,
    output logic [TW-1:0] remaining_time,
    output logic [CW-1:0] transition_count,
    output logic input_bad
);
    import dtl_pkg::*;

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    logic [DTL_NUM_IN-1:0] din_s;
    logic [DTL_NUM_IN-1:0] def_s;
    logic rst_s;

    dtl_sync #(.W(2*DTL_NUM_IN+1)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({din, din_defined, timer_reset_in}),
        .q({din_s, def_s, rst_s})
    );

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    logic [DTL_NUM_IN-1:0] in_val;
    logic [DTL_NUM_IN-1:0] in_use;
    logic rst_val;
    logic comb_now;
    logic bad_now;

    // invert inputs before use, drop undefined unconnected ones
    always_comb begin
        in_val = din_s ^ inversion_select[DTL_INV_IN0_POS +: DTL_NUM_IN];
        in_use = def_s;
        bad_now = |(din_connected & ~def_s);
        rst_val = rst_s ^ inversion_select[DTL_INV_RST_POS];
    end

    dtl_combiner u_comb (
        .in_val(in_val),
        .in_use(in_use),
        .input_combine_select(input_combine_select),
        .combined(comb_now)
    );

    // ----------------------------------------
    // sampled state per execution
    // ----------------------------------------
    logic comb_ff;
    logic rst_ff;
    logic pre_ff;
    logic bad_ff;
    dtl_state_t state_ff;
    logic [TW-1:0] exp_ff;
    logic [TW-1:0] rem_ff;
    logic [CW-1:0] cnt_ff;
    logic [DTL_NUM_IN-1:0] man_ff;

    logic rise;
    logic fall;
    logic rst_rise;
    logic comb_eff;

    // a bad connected input forces the combined input false
    always_comb begin
        comb_eff = comb_now & ~bad_now;
        rise = comb_eff & ~comb_ff;
        fall = ~comb_eff & comb_ff;
        rst_rise = rst_val & ~rst_ff;
    end

    // previous-sample registers, updated once per tick
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            comb_ff <= 1'b0;
            rst_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else if (exec_tick) begin
            comb_ff <= comb_eff;
            rst_ff <= rst_val;
            bad_ff <= bad_now;
        end
    end

    // ----------------------------------------
    // transition counter
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= CW'(DTL_CNT_RST);
        end else if (exec_tick) begin
            if (rst_rise) begin
                cnt_ff <= CW'(DTL_CNT_RST);
            end else if (rise) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // timing engine
    // ----------------------------------------
    logic nxt_pre;
    dtl_state_t nxt_state;
    logic [TW-1:0] nxt_exp;
    logic [TW-1:0] nxt_rem;
    logic quiet;
    logic [TW-1:0] exp_inc;
    logic [TW-1:0] rem_dec;
    logic sp_hit;
    logic [TW-1:0] exp_q;
    logic [TW-1:0] rem_q;

    // saturating step helpers
    function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction : sat_inc

    function automatic logic [TW-1:0] sat_dec(input logic [TW-1:0] v);
        sat_dec = (v == '0) ? v : v - 1'b1;
    endfunction : sat_dec

    // next timer state for the selected function
    always_comb begin
        exp_inc = sat_inc(exp_ff);
        rem_dec = (exp_inc >= interval_setpoint) ? '0 : interval_setpoint - exp_inc;
        sp_hit = (exp_inc >= interval_setpoint);
        exp_q = (idle_value_option == DTL_QOPT_CLEAR) ? '0 : exp_ff;
        rem_q = (idle_value_option == DTL_QOPT_CLEAR) ? '0 : rem_ff;
        nxt_pre = pre_ff;
        nxt_state = state_ff;
        nxt_exp = exp_ff;
        nxt_rem = rem_ff;
        quiet = 1'b0;
        unique case (timer_function_select)
            DTL_TMR_MEASURE: begin
                nxt_pre = comb_eff;
                nxt_rem = '0;
                quiet = ~comb_eff;
                nxt_exp = rise ? TW'(1) : (comb_eff ? exp_inc : exp_q);
            end
            DTL_TMR_ACCUMULATE: begin
                nxt_pre = comb_eff;
                nxt_rem = '0;
                nxt_exp = comb_eff ? exp_inc : exp_ff;
            end
            DTL_TMR_COMPARE, DTL_TMR_DELAY: begin
                quiet = ~comb_eff;
                if (!comb_eff) begin
                    nxt_pre = 1'b0;
                    nxt_exp = exp_q;
                    nxt_rem = rem_q;
                end else begin
                    nxt_exp = rise ? TW'(1) : exp_inc;
                    nxt_rem = rise ? sat_dec(interval_setpoint) : rem_dec;
                    nxt_pre = rise ? (interval_setpoint <= TW'(1)) : sp_hit;
                end
            end
            DTL_TMR_EXTEND: begin
                quiet = comb_eff;
                if (comb_eff) begin
                    nxt_pre = 1'b1;
                    nxt_exp = exp_q;
                    nxt_rem = rem_q;
                end else if (pre_ff) begin
                    nxt_exp = fall ? TW'(1) : exp_inc;
                    nxt_rem = fall ? sat_dec(interval_setpoint) : rem_dec;
                    nxt_pre = fall ? (interval_setpoint > TW'(1)) : ~sp_hit;
                end
            end
            DTL_TMR_DEBOUNCE: begin
                quiet = (comb_eff == pre_ff);
                if (comb_eff == pre_ff) begin
                    nxt_exp = exp_q;
                    nxt_rem = rem_q;
                end else begin
                    nxt_exp = (rise | fall) ? TW'(1) : exp_inc;
                    nxt_rem = (rise | fall) ? sat_dec(interval_setpoint) : rem_dec;
                    if ((rise | fall) ? (interval_setpoint <= TW'(1)) : sp_hit) begin
                        nxt_pre = comb_eff;
                    end
                end
            end
            default: begin // pulse and retrigger pulse
                quiet = (state_ff != DTL_ST_RUN) && !comb_eff;
                if (rise && (state_ff != DTL_ST_RUN ||
                    timer_function_select == DTL_TMR_RETRIGGER)) begin
                    nxt_state = DTL_ST_RUN;
                    nxt_pre = 1'b1;
                    nxt_exp = TW'(1);
                    nxt_rem = sat_dec(interval_setpoint);
                    if (interval_setpoint <= TW'(1)) begin
                        nxt_state = DTL_ST_DONE;
                        nxt_pre = 1'b0;
                    end
                end else if (state_ff == DTL_ST_RUN) begin
                    nxt_exp = exp_inc;
                    nxt_rem = rem_dec;
                    if (sp_hit) begin
                        nxt_state = DTL_ST_DONE;
                        nxt_pre = 1'b0;
                    end
                end else begin
                    nxt_state = comb_eff ? DTL_ST_DONE : DTL_ST_IDLE;
                    if (!comb_eff) begin
                        nxt_exp = exp_q;
                        nxt_rem = rem_q;
                    end
                end
            end
        endcase
    end

    // timer registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pre_ff <= 1'b0;
            state_ff <= DTL_ST_IDLE;
            exp_ff <= TW'(DTL_TIME_RST);
            rem_ff <= TW'(DTL_TIME_RST);
        end else if (exec_tick) begin
            pre_ff <= nxt_pre;
            state_ff <= nxt_state;
            exp_ff <= rst_rise ? '0 : nxt_exp;
            rem_ff <= rst_rise ? '0 : nxt_rem;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // output follows pre-output in auto mode, then inversion
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            man_ff <= '0;
            discrete_output <= 1'b0;
            pre_output <= 1'b0;
            combined_input <= 1'b0;
            elapsed_time <= '0;
            remaining_time <= '0;
            transition_count <= '0;
            input_bad <= 1'b0;
        end else begin
            man_ff <= manual_out;
            discrete_output <= (auto_mode ? pre_ff : man_ff[0]) ^ inversion_select[DTL_INV_OUT_POS];
            pre_output <= pre_ff ^ inversion_select[DTL_INV_PRE_POS];
            combined_input <= comb_ff;
            elapsed_time <= exp_ff;
            remaining_time <= rem_ff;
            transition_count <= cnt_ff;
            input_bad <= bad_ff;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_rst_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && rst_rise) |=> (exp_ff == '0 && rem_ff == '0);
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset edge did not zero times");
    property p_cnt_rise;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && rise && !rst_rise) |=> (cnt_ff == $past(cnt_ff) + 1'b1);
    endproperty
    a_cnt_rise: assert property (p_cnt_rise) else $error("rising edge not counted");
    property p_cnt_clr;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && rst_rise) |=> (cnt_ff == '0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
    property p_measure;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && timer_function_select == DTL_TMR_MEASURE) |=> (pre_ff == $past(comb_eff) && rem_ff == '0);
    endproperty
    a_measure: assert property (p_measure) else $error("measure output wrong");
    property p_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && quiet && idle_value_option == DTL_QOPT_CLEAR) |=> (exp_ff == '0 && rem_ff == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("quiescent clear not applied");
    property p_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && quiet && !rst_rise && idle_value_option == DTL_QOPT_LAST &&
         timer_function_select != DTL_TMR_MEASURE) |=> ($stable(rem_ff) && $stable(exp_ff));
    endproperty
    a_hold: assert property (p_hold) else $error("quiescent last not held");
    property p_norepeat;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && timer_function_select == DTL_TMR_PULSE && state_ff == DTL_ST_RUN && !sp_hit
         && !rst_rise) |=> (pre_ff && exp_ff == $past(exp_inc));
    endproperty
    a_norepeat: assert property (p_norepeat) else $error("pulse retriggered");
    property p_retrig;
        @(posedge ref_clk) disable iff (!rstn)
        (exec_tick && timer_function_select == DTL_TMR_RETRIGGER && rise && !rst_rise
         && interval_setpoint > TW'(1)) |=> (pre_ff && exp_ff == TW'(1));
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger did not restart");

    property p_auto;
        @(posedge ref_clk) disable iff (!rstn)
        auto_mode ##1 auto_mode |=> (discrete_output == ($past(pre_ff) ^ $past(inversion_select[DTL_INV_OUT_POS])));
    endproperty
    a_auto: assert property (p_auto) else $error("output does not follow pre-output");

    property p_tick;
        @(posedge ref_clk) disable iff (!rstn)
        !exec_tick |=> ($stable(exp_ff) && $stable(cnt_ff) && $stable(pre_ff));
    endproperty
    a_tick: assert property (p_tick) else $error("state moved without tick");
endmodule : dtl_timer_logic_unit

// File: testbench/dtl_src_model.sv
// Purpose: upstream source model, makes the execution tick for the unit
// Assumes: one clock, tick launched off the falling edge
// Notes: tick spacing is a parameter
`timescale 1ns/1ps
module dtl_src_model #(
    parameter int DIV = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    output logic exec_tick
);
    int cnt;
    // one-cycle tick every DIV cycles, never two edges wide
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            exec_tick <= 1'b0;
        end else begin
            cnt <= (cnt + 1) % DIV;
            exec_tick <= (cnt == 0);
        end
    end
endmodule : dtl_src_model

// File: testbench/dtl_timer_logic_unit_bench.sv
// Purpose: self-checking bench for the timer and logic unit
// Assumes: inputs change at the falling edge, outputs sampled two edges after a tick
// Notes: timing checks are counted in execution ticks
`timescale 1ns/1ps
module dtl_timer_logic_unit_bench;
    import dtl_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic exec_tick;
    logic [3:0] din = 4'h0;
    logic [3:0] din_defined = 4'hF;
    logic [3:0] din_connected = 4'hF;
    logic [3:0] manual_out = 4'h0;
    logic timer_reset_in = 1'b0;
    logic auto_mode = 1'b1;
    dtl_comb_t input_combine_select = DTL_CMB_OR;
    dtl_timer_t timer_function_select = DTL_TMR_MEASURE;
    dtl_qopt_t idle_value_option = DTL_QOPT_CLEAR;
    logic [6:0] inversion_select = 7'h00;
    logic [15:0] interval_setpoint = 16'h0005;
    logic combined_input, pre_output, discrete_output, input_bad;
    logic [15:0] elapsed_time, remaining_time, transition_count;
    logic [15:0] a, b;
    logic pre_seen = 1'b0;
    int err_total = 0;
    int comparisons = 0;
    int k, n, m;

    // ----------------------------------------
    // clock, source model, unit
    // ----------------------------------------
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    dtl_src_model u_src (.ref_clk(ref_clk), .rstn(rstn), .exec_tick(exec_tick));
    dtl_timer_logic_unit u_dut (.ref_clk(ref_clk), .rstn(rstn), .exec_tick(exec_tick), .din(din),
        .din_defined(din_defined), .din_connected(din_connected), .timer_reset_in(timer_reset_in),
        .input_combine_select(input_combine_select), .timer_function_select(timer_function_select),
        .idle_value_option(idle_value_option), .inversion_select(inversion_select),
        .interval_setpoint(interval_setpoint), .auto_mode(auto_mode), .manual_out(manual_out),
        .combined_input(combined_input), .pre_output(pre_output), .discrete_output(discrete_output),
        .elapsed_time(elapsed_time), .remaining_time(remaining_time),
        .transition_count(transition_count), .input_bad(input_bad));
    // sticky flag so a hidden transition can be proven absent
    always @(posedge ref_clk) begin
        if (pre_output === 1'b1) pre_seen = 1'b1;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic finish_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // step t ticks, then let the answer land
    task automatic ticks(input int t);
        repeat (t) @(posedge ref_clk iff exec_tick === 1'b1);
        repeat (2) @(negedge ref_clk);
    endtask : ticks
    // bounded wait, in ticks, for pre-output (w=1) or combined input (w=0)
    task automatic wait_lvl(input bit w, input logic lvl, output int c);
        c = 0;
        while ((w ? pre_output : combined_input) !== lvl) begin
            ticks(1);
            c++;
            if (c > 200) begin
                err_total++;
                finish_test();
            end
        end
    endtask : wait_lvl
    function automatic logic exp_comb(input dtl_comb_t s, input int c);
        case (s)
            DTL_CMB_OR: return c >= 1;
            DTL_CMB_TWO_OR_MORE: return c >= 2;
            DTL_CMB_THREE_OR_MORE: return c >= 3;
            DTL_CMB_AND: return c == 4;
            DTL_CMB_EXACT_ONE: return c == 1;
            DTL_CMB_EXACT_TWO: return c == 2;
            DTL_CMB_EXACT_THREE: return c == 3;
            DTL_CMB_EVEN: return c % 2 == 0;
            default: return c % 2 == 1;
        endcase
    endfunction : exp_comb

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        ticks(1);
        chk("count_rst", 16'h0000, transition_count);
        chk("elapsed_rst", 16'h0000, elapsed_time);
        // every selector against every count of true inputs
        for (k = 0; k < 45; k++) begin
            input_combine_select = dtl_comb_t'(k / 5);
            din = 4'(4'hF >> (4 - k % 5));
            ticks(3);
            chk("combined", 16'(exp_comb(input_combine_select, k % 5)), 16'(combined_input));
        end
        input_combine_select = DTL_CMB_OR;
        din = 4'h0;
        timer_reset_in = 1'b1;
        ticks(3);
        chk("count_clr", 16'h0000, transition_count);
        timer_reset_in = 1'b0;
        for (k = 0; k < 3; k++) begin
            din = 4'h1;
            ticks(3);
            din = 4'h0;
            ticks(3);
        end
        chk("count", 16'h0003, transition_count);
        // undefined inputs, unconnected then connected
        input_combine_select = DTL_CMB_AND;
        din = 4'h7;
        din_defined = 4'h7;
        din_connected = 4'h7;
        ticks(3);
        chk("and_unconn", 16'h0001, 16'(combined_input));
        din_connected = 4'hF;
        ticks(3);
        chk("and_bad", 16'h0000, 16'(combined_input));
        chk("bad_flag", 16'h0001, 16'(input_bad));
        din_defined = 4'hF;
        input_combine_select = DTL_CMB_OR;
        din = 4'h0;
        inversion_select = 7'h01;
        ticks(3);
        chk("inv_in", 16'h0001, 16'(combined_input));
        inversion_select = 7'h20;
        ticks(3);
        chk("inv_out", 16'(!pre_output), 16'(discrete_output));
        inversion_select = 7'h00;
        din = 4'h1;
        ticks(3);
        chk("auto_out", 16'(pre_output), 16'(discrete_output));
        auto_mode = 1'b0;
        ticks(3);
        chk("manual_out", 16'h0000, 16'(discrete_output));
        auto_mode = 1'b1;
        // measure: elapsed grows one per tick while true
        din = 4'h0;
        ticks(3);
        din = 4'h1;
        wait_lvl(1'b0, 1'b1, n);
        a = elapsed_time;
        ticks(4);
        chk("meas_elapsed", a + 16'h0004, elapsed_time);
        chk("meas_rem", 16'h0000, remaining_time);
        chk("meas_pre", 16'h0001, 16'(pre_output));
        din = 4'h0;
        ticks(3);
        chk("meas_idle", 16'h0000, elapsed_time);
        // delay: output rises when elapsed reaches the setpoint
        timer_function_select = DTL_TMR_DELAY;
        ticks(3);
        din = 4'h1;
        wait_lvl(1'b0, 1'b1, n);
        chk("dly_rem", interval_setpoint - elapsed_time, remaining_time);
        ticks(1);
        chk("dly_rem_run", interval_setpoint - elapsed_time, remaining_time);
        wait_lvl(1'b1, 1'b1, n);
        chk("dly_exp", interval_setpoint, elapsed_time);
        chk("dly_rem0", 16'h0000, remaining_time);
        din = 4'h0;
        ticks(3);
        chk("dly_fall", 16'h0000, 16'(pre_output));
        chk("dly_idle", 16'h0000, elapsed_time | remaining_time);
        pre_seen = 1'b0;
        din = 4'h1;
        ticks(3);
        din = 4'h0;
        ticks(8);
        chk("dly_short", 16'h0000, 16'(pre_seen));
        // last option holds both times; timer reset zeroes them
        idle_value_option = DTL_QOPT_LAST;
        din = 4'h1;
        wait_lvl(1'b0, 1'b1, n);
        ticks(2);
        din = 4'h0;
        ticks(3);
        a = elapsed_time;
        b = remaining_time;
        ticks(4);
        chk("last_exp", a, elapsed_time);
        chk("last_rem", b, remaining_time);
        timer_reset_in = 1'b1;
        ticks(3);
        chk("rst_times", 16'h0000, elapsed_time | remaining_time);
        timer_reset_in = 1'b0;
        idle_value_option = DTL_QOPT_CLEAR;
        // pulse widths: clean, glitched, glitched with retrigger
        interval_setpoint = 16'h000C;
        for (k = 0; k < 3; k++) begin
            timer_function_select = (k == 2) ? DTL_TMR_RETRIGGER : DTL_TMR_PULSE;
            ticks(3);
            din = 4'h1;
            wait_lvl(1'b1, 1'b1, n);
            din = 4'h0;
            if (k > 0) begin
                ticks(2);
                din = 4'h1;
                ticks(2);
                din = 4'h0;
            end
            wait_lvl(1'b1, 1'b0, n);
            if (k == 0) m = n;
            if (k == 1) chk("pulse_len", 16'(m), 16'(n + 4));
            if (k == 2) chk("retrig_len", 16'h0001, 16'(n + 4 > m));
        end
        ticks(1);
        chk("pulse_idle", 16'h0000, elapsed_time | remaining_time);
        // extend holds off a fall, debounce a rise, each by setpoint ticks
        for (k = 0; k < 2; k++) begin
            timer_function_select = (k == 1) ? DTL_TMR_DEBOUNCE : DTL_TMR_EXTEND;
            din = 4'(1 - k);
            ticks(3);
            din = 4'(k);
            wait_lvl(1'b1, k[0], n);
            chk("hold_len", interval_setpoint, 16'(n));
        end
        finish_test();
    end
endmodule : dtl_timer_logic_unit_bench
